// *** core/sat_tx.v ***
// Serial audio transmitter: bit clock, frame sync and data shifting.
// Assumes one clock clk_i with synchronous active high reset_i; registers over AXI4-Lite.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`include "sat_consts.vh"
module sat_tx #(
	parameter DIV_W = 12
) (
	input  wire        clk_i,
	input  wire        reset_i,
	input  wire [7:0]  s_axi_awaddr_i,
	input  wire        s_axi_awvalid_i,
	output reg         s_axi_awready_o,
	input  wire [31:0] s_axi_wdata_i,
	input  wire [3:0]  s_axi_wstrb_i,
	input  wire        s_axi_wvalid_i,
	output reg         s_axi_wready_o,
	output reg  [1:0]  s_axi_bresp_o,
	output reg         s_axi_bvalid_o,
	input  wire        s_axi_bready_i,
	input  wire [7:0]  s_axi_araddr_i,
	input  wire        s_axi_arvalid_i,
	output reg         s_axi_arready_o,
	output reg  [31:0] s_axi_rdata_o,
	output reg  [1:0]  s_axi_rresp_o,
	output reg         s_axi_rvalid_o,
	input  wire        s_axi_rready_i,
	output reg         tx_bit_clock_o,
	output reg         tx_sync_o,
	output reg         tx_data_o,
	output reg         word_request_o
);
	// ==========================================================
	// Registers
	reg [31:0]      ctrl;
	reg [31:0]      tx_clock_mode_setting;
	reg [31:0]      tx_frame_mode_setting;
	reg [DIV_W-1:0] divider;
	reg [31:0]      left_word;
	reg [31:0]      right_word;
	reg             underrun;
	reg [7:0]       aw_addr;
	reg [31:0]      w_data;
	reg [3:0]       w_strb;
	reg             aw_held;
	reg             w_held;
	reg             running;
	reg             clk_en;
	reg [DIV_W:0]   div_cnt;
	reg             bclk;
	reg [7:0]       half_cnt;
	reg [7:0]       dly_cnt;
	reg             waiting;
	reg             shifting;
	reg [4:0]       bit_cnt;
	reg [3:0]       word_cnt;
	reg [31:0]      shreg;
	reg             sync_q;
	reg             loaded;
	wire [1:0]  tx_clock_source_select = tx_clock_mode_setting[`SAT_CM_SRC_LSB +: 2];
	wire        clk_out_mode  = tx_clock_mode_setting[`SAT_CM_CKO];
	wire        clk_invert    = tx_clock_mode_setting[`SAT_CM_CKI];
	wire [1:0]  tx_clock_gating = tx_clock_mode_setting[`SAT_CM_GATE_LSB +: 2];
	wire [2:0]  start_select  = tx_clock_mode_setting[`SAT_CM_START_LSB +: 3];
	wire [7:0]  tx_start_delay = tx_clock_mode_setting[`SAT_CM_DLY_LSB +: 8];
	wire [7:0]  period_field  = tx_clock_mode_setting[`SAT_CM_PER_LSB +: 8];
	wire [4:0]  word_length_field = tx_frame_mode_setting[`SAT_FM_LEN_LSB +: 5];
	wire        idle_data_value = tx_frame_mode_setting[`SAT_FM_DEF];
	wire [3:0]  words_per_frame_field = tx_frame_mode_setting[`SAT_FM_NB_LSB +: 4];
	wire [3:0]  sync_pulse_length = tx_frame_mode_setting[`SAT_FM_FSL_LSB +: 4];
	wire [3:0]  sync_length_extension = tx_frame_mode_setting[`SAT_FM_FSEXT_LSB +: 4];
	wire        sync_data_enable = tx_frame_mode_setting[`SAT_FM_SDEN];
	wire        sync_edge_select = tx_frame_mode_setting[`SAT_FM_SEDGE];
	wire        enable        = ctrl[0];
	// ==========================================================
	// AXI4-Lite slave
	wire        do_write = aw_held && w_held && !s_axi_bvalid_o;
	wire        aw_ok = (aw_addr[1:0] == 2'h0) && (aw_addr <= `SAT_ADDR_RIGHT);
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  st;
		integer k;
		begin
			for (k = 0; k < 4; k = k + 1) begin
				merge[k*8 +: 8] = st[k] ? nw[k*8 +: 8] : old[k*8 +: 8];
			end
		end
	endfunction
	wire [31:0] div_merged = merge({{(32-DIV_W){1'b0}}, divider}, w_data, w_strb);
	always @(posedge clk_i) begin
		if (reset_i) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o <= 1'b1;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `SAT_RESP_OKAY;
			ctrl <= 32'h00000000;
			tx_clock_mode_setting <= `SAT_CLKMODE_RST;
			tx_frame_mode_setting <= `SAT_FRMMODE_RST;
			divider <= `SAT_DIV_RST;
			left_word <= 32'h00000000;
			right_word <= 32'h00000000;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_addr <= s_axi_awaddr_i;
				aw_held <= 1'b1;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data <= s_axi_wdata_i;
				w_strb <= s_axi_wstrb_i;
				w_held <= 1'b1;
				s_axi_wready_o <= 1'b0;
			end
			if (do_write) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o <= aw_ok ? `SAT_RESP_OKAY : `SAT_RESP_SLVERR;
				case (aw_addr)
					`SAT_ADDR_CTRL:    ctrl <= merge(ctrl, w_data, w_strb);
					`SAT_ADDR_CLKMODE: tx_clock_mode_setting <= merge(tx_clock_mode_setting, w_data, w_strb);
					`SAT_ADDR_FRMMODE: tx_frame_mode_setting <= merge(tx_frame_mode_setting, w_data, w_strb);
					`SAT_ADDR_DIV:     divider <= div_merged[DIV_W-1:0];
					`SAT_ADDR_LEFT:    left_word <= merge(left_word, w_data, w_strb);
					`SAT_ADDR_RIGHT:   right_word <= merge(right_word, w_data, w_strb);
					default: ;
				endcase
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o <= 1'b0;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o <= 1'b1;
			end
		end
	end
	always @(posedge clk_i) begin
		if (reset_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= 32'h00000000;
			s_axi_rresp_o <= `SAT_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_arready_o <= 1'b0;
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= `SAT_RESP_OKAY;
			case (s_axi_araddr_i)
				`SAT_ADDR_CTRL:    s_axi_rdata_o <= ctrl;
				`SAT_ADDR_CLKMODE: s_axi_rdata_o <= tx_clock_mode_setting;
				`SAT_ADDR_FRMMODE: s_axi_rdata_o <= tx_frame_mode_setting;
				`SAT_ADDR_DIV:     s_axi_rdata_o <= {{(32-DIV_W){1'b0}}, divider};
				`SAT_ADDR_LEFT:    s_axi_rdata_o <= left_word;
				`SAT_ADDR_RIGHT:   s_axi_rdata_o <= right_word;
				`SAT_ADDR_STATUS:  s_axi_rdata_o <= {29'h0, underrun, shifting, running};
				default: begin
					s_axi_rdata_o <= 32'h00000000;
					s_axi_rresp_o <= `SAT_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid_o && s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_arready_o <= 1'b1;
		end
	end
	// ==========================================================
	// Bit clock divider
	// Half period of the bit clock is 2 * divider peripheral clocks.
	wire [DIV_W:0] half_div = {divider, 1'b0};
	wire           div_ok = (divider != {DIV_W{1'b0}});
	always @(posedge clk_i) begin
		if (reset_i) begin
			running <= 1'b0;
			div_cnt <= {(DIV_W+1){1'b0}};
			clk_en <= 1'b0;
			bclk <= 1'b0;
		end else begin
			running <= enable && div_ok && (tx_clock_source_select == 2'h0);
			clk_en <= 1'b0;
			if (!running) begin
				div_cnt <= {(DIV_W+1){1'b0}};
				bclk <= 1'b0;
			end else if (div_cnt == half_div - 1'b1) begin
				div_cnt <= {(DIV_W+1){1'b0}};
				bclk <= ~bclk;
				clk_en <= 1'b1;
			end else begin
				div_cnt <= div_cnt + 1'b1;
			end
		end
	end
	// A falling bit clock edge is the shift edge unless inverted.
	wire shift_edge = clk_en && (bclk == clk_invert);
	// ==========================================================
	// Frame sync, start delay and shifter
	wire [7:0] sync_len = {sync_length_extension, sync_pulse_length} + 8'h01;
	wire       next_sync = (half_cnt < sync_len) ^ sync_edge_select;
	wire       start_hit = (start_select == `SAT_START_EDGE) && (next_sync != sync_q)
		&& (next_sync == !sync_edge_select);
	// The frame is two periods long; the period field is taken modulo 128.
	wire [7:0]  frame_last = {period_field[6:0], 1'b1};
	wire [31:0] left_aligned = left_word << (5'd31 - word_length_field);
	wire [31:0] right_aligned = right_word << (5'd31 - word_length_field);
	// The first bit leaves at the shift edge that ends the start delay.
	wire        begin_now = start_hit ? (tx_start_delay == 8'h00)
		: (waiting && (dly_cnt == 8'h01));
	wire        active = begin_now || shifting;
	wire [31:0] cur_bits_word = begin_now ? left_aligned : shreg;
	wire [4:0]  cur_bits = begin_now ? word_length_field : bit_cnt;
	wire [3:0]  cur_index = begin_now ? 4'h0 : word_cnt;
	always @(posedge clk_i) begin
		if (reset_i) begin
			half_cnt <= 8'h00;
			sync_q <= 1'b0;
			dly_cnt <= 8'h00;
			waiting <= 1'b0;
			shifting <= 1'b0;
			bit_cnt <= 5'h00;
			word_cnt <= 4'h0;
			shreg <= 32'h00000000;
			loaded <= 1'b0;
			underrun <= 1'b0;
			word_request_o <= 1'b0;
			tx_bit_clock_o <= 1'b0;
			tx_sync_o <= 1'b0;
			tx_data_o <= 1'b0;
		end else begin
			word_request_o <= 1'b0;
			tx_bit_clock_o <= bclk && (clk_out_mode || shifting) && (tx_clock_gating == 2'h0);
			if (!running) begin
				half_cnt <= 8'h00;
				sync_q <= sync_edge_select;
				waiting <= 1'b0;
				shifting <= 1'b0;
				tx_sync_o <= sync_edge_select;
				tx_data_o <= idle_data_value;
			end else if (shift_edge) begin
				half_cnt <= (half_cnt == frame_last) ? 8'h00 : half_cnt + 8'h01;
				sync_q <= next_sync;
				tx_sync_o <= next_sync;
				if (start_hit && (tx_start_delay != 8'h00)) begin
					waiting <= 1'b1;
					dly_cnt <= tx_start_delay;
				end else if (waiting) begin
					dly_cnt <= dly_cnt - 8'h01;
					if (dly_cnt == 8'h01) begin
						waiting <= 1'b0;
					end
				end
				if (active) begin
					shifting <= 1'b1;
					tx_data_o <= cur_bits_word[31];
					shreg <= {cur_bits_word[30:0], 1'b0};
					bit_cnt <= cur_bits - 5'h01;
					word_cnt <= cur_index;
					if (cur_bits == 5'h00) begin
						bit_cnt <= word_length_field;
						if (cur_index == words_per_frame_field) begin
							shifting <= 1'b0;
							word_request_o <= 1'b1;
							underrun <= !loaded;
							loaded <= 1'b0;
						end else begin
							word_cnt <= cur_index + 4'h1;
							shreg <= cur_index[0] ? left_aligned : right_aligned;
						end
					end
				end else begin
					tx_data_o <= idle_data_value;
				end
			end
			if (do_write && (aw_addr == `SAT_ADDR_RIGHT)) begin
				loaded <= 1'b1;
			end
		end
	end
endmodule

// *** inc/sat_consts.vh ***
// Constants for the serial audio transmit clock and frame generator.
// Assumes a single 125 MHz clock and an AXI4-Lite master with 32-bit data.
`ifndef SAT_CONSTS_VH
`define SAT_CONSTS_VH
`define SAT_ADDR_CTRL    8'h00
`define SAT_ADDR_CLKMODE 8'h04
`define SAT_ADDR_FRMMODE 8'h08
`define SAT_ADDR_DIV     8'h0c
`define SAT_ADDR_LEFT    8'h10
`define SAT_ADDR_RIGHT   8'h14
`define SAT_ADDR_STATUS  8'h18
// Clock mode fields.
`define SAT_CM_SRC_LSB   0
`define SAT_CM_CKO       2
`define SAT_CM_CKI       5
`define SAT_CM_GATE_LSB  6
`define SAT_CM_START_LSB 8
`define SAT_CM_DLY_LSB   16
`define SAT_CM_PER_LSB   24
// Frame mode fields.
`define SAT_FM_LEN_LSB   0
`define SAT_FM_DEF       5
`define SAT_FM_NB_LSB    8
`define SAT_FM_FSL_LSB   16
`define SAT_FM_FSEXT_LSB 28
`define SAT_FM_SDEN      23
`define SAT_FM_SEDGE     24
// Reset values: 16-bit stereo frame, one cycle start delay.
`define SAT_CLKMODE_RST  32'h0f010704
`define SAT_FRMMODE_RST  32'h000f010f
`define SAT_DIV_RST      12'h031
`define SAT_START_EDGE   3'h7
`define SAT_RESP_OKAY    2'h0
`define SAT_RESP_SLVERR  2'h2
`endif

// *** test/sat_codec.sv ***
// Codec model: a serial slave that collects each frame.
// Assumes bit clock, frame sync and data driven by the transmitter.
module sat_codec (
	input  logic        bclk_i,
	input  logic        sync_i,
	input  logic        data_i,
	output logic [31:0] frame_o,
	output logic [7:0]  frames_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// Data is taken on the rising bit clock; a rising sync closes a frame.
	logic [31:0] sr = 32'h0;
	logic        last = 1'h0;
	initial begin
		frame_o = 32'h0;
		frames_o = 8'h0;
	end
	always @(posedge bclk_i) begin
		sr <= {sr[30:0], data_i};
		last <= sync_i;
		if (sync_i && !last) begin
			frame_o <= {sr[30:0], data_i};
			frames_o <= frames_o + 8'h1;
		end
	end
endmodule

// *** test/sat_tx_props.sv ***
// Port checker for the serial audio transmitter.
// Assumes clk_i with synchronous active high reset_i.
module sat_props (
	input logic clk_i,
	input logic reset_i,
	input logic s_axi_awvalid_i,
	input logic s_axi_awready_o,
	input logic s_axi_wvalid_i,
	input logic s_axi_wready_o,
	input logic s_axi_bvalid_o,
	input logic s_axi_bready_i,
	input logic s_axi_arvalid_i,
	input logic s_axi_arready_o,
	input logic s_axi_rvalid_o,
	input logic s_axi_rready_i,
	input logic tx_bit_clock_o,
	input logic tx_sync_o,
	input logic tx_data_o,
	input logic word_request_o
);
	// ====
	// Assertions.
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	a_bvalid_holds: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
		else $error("Write response dropped early.");
	a_rvalid_holds: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o)
		else $error("Read response dropped early.");
	a_write_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
		&& s_axi_wready_o |-> ##2 s_axi_bvalid_o) else $error("Late write response.");
	a_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("Late read response.");
	a_busy_ready: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
		else $error("Address ready while response waits.");
	a_clock_high: assert property ($rose(tx_bit_clock_o) |-> tx_bit_clock_o[*2])
		else $error("Bit clock high phase too short.");
	a_data_fall: assert property ($changed(tx_data_o) |-> $fell(tx_bit_clock_o))
		else $error("Data changed off the falling bit clock.");
	a_sync_fall: assert property ($changed(tx_sync_o) |-> $fell(tx_bit_clock_o))
		else $error("Sync changed off the falling bit clock.");
	a_request_pulse: assert property (word_request_o |=> !word_request_o)
		else $error("Word request longer than one cycle.");
endmodule
bind sat_tx sat_props sat_props_i (.clk_i, .reset_i, .s_axi_awvalid_i, .s_axi_awready_o,
	.s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
	.s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i, .tx_bit_clock_o, .tx_sync_o,
	.tx_data_o, .word_request_o);

// *** test/tb.sv ***
// Testbench for the serial audio transmitter.
// Assumes the codec model and the bound port checker.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'h0;
	logic        reset_i = 1'h1;
	logic [7:0]  s_axi_awaddr_i = 8'h0;
	logic [7:0]  s_axi_araddr_i = 8'h0;
	logic [31:0] s_axi_wdata_i = 32'h0;
	logic [3:0]  s_axi_wstrb_i = 4'hf;
	logic        s_axi_awvalid_i = 1'h0;
	logic        s_axi_wvalid_i = 1'h0;
	logic        s_axi_bready_i = 1'h0;
	logic        s_axi_arvalid_i = 1'h0;
	logic        s_axi_rready_i = 1'h0;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic        s_axi_rvalid_o, tx_bit_clock_o, tx_sync_o, tx_data_o, word_request_o;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, rsp;
	logic [31:0] s_axi_rdata_o, frame, rd, lw, rw;
	logic [7:0]  frames;
	int          bad_count = 0, checked = 0, cyc = 0, n;
	sat_tx sat_tx_i (.clk_i, .reset_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
		.s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
		.s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
		.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .tx_bit_clock_o,
		.tx_sync_o, .tx_data_o, .word_request_o);
	sat_codec sat_codec_i (.bclk_i(tx_bit_clock_o), .sync_i(tx_sync_o), .data_i(tx_data_o),
		.frame_o(frame), .frames_o(frames));
	// ====
	// Clock, timeout and helpers.
	initial begin
		forever #4 clk_i = ~clk_i;
	end
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			conclude();
		end
	end
	function automatic int bit_clks(input int div);
		return 4 * div;
	endfunction
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", s, e, g);
			bad_count++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_awvalid_i <= 1'h1;
		s_axi_wvalid_i <= 1'h1;
		s_axi_bready_i <= 1'h1;
		do begin
			@(posedge clk_i);
			if (s_axi_awready_o) s_axi_awvalid_i <= 1'h0;
			if (s_axi_wready_o) s_axi_wvalid_i <= 1'h0;
		end while (s_axi_bvalid_o !== 1'h1);
		s_axi_bready_i <= 1'h0;
		rsp = s_axi_bresp_o;
		@(posedge clk_i);
	endtask
	task automatic rdr(input logic [7:0] a);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		s_axi_rready_i <= 1'h1;
		do begin
			@(posedge clk_i);
			if (s_axi_arready_o) s_axi_arvalid_i <= 1'h0;
		end while (s_axi_rvalid_o !== 1'h1);
		s_axi_rready_i <= 1'h0;
		rd = s_axi_rdata_o;
		rsp = s_axi_rresp_o;
		@(posedge clk_i);
	endtask
	task automatic hlen(input bit sel);
		n = 0;
		while ((sel ? tx_sync_o : tx_bit_clock_o) !== 1'h0) @(posedge clk_i);
		while ((sel ? tx_sync_o : tx_bit_clock_o) !== 1'h1) @(posedge clk_i);
		while ((sel ? tx_sync_o : tx_bit_clock_o) === 1'h1) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ====
	// Main sequence.
	initial begin
		void'($urandom(22387));
		repeat (2) @(posedge clk_i);
		reset_i <= 1'h0;
		@(posedge clk_i);
		rdr(8'h04);
		chk("clock mode", 32'h0f010704, rd);
		rdr(8'h08);
		chk("frame mode", 32'h000f010f, rd);
		rdr(8'h0c);
		chk("divider", 32'h31, rd);
		rdr(8'h40);
		chk("unmapped read", 32'h0, rd);
		chk("unmapped read resp", 32'h2, {30'h0, rsp});
		wr(8'h44, 32'h5a5a5a5a);
		chk("unmapped write", 32'h2, rsp);
		wr(8'h0c, 32'h1);
		wr(8'h00, 32'h1);
		for (int i = 0; i < 4; i++) begin
			lw = (i == 0) ? 32'h8001 : ($urandom & 32'hffff);
			rw = (i == 0) ? 32'h7ffe : ($urandom & 32'hffff);
			repeat (3) begin
				do @(posedge clk_i); while (word_request_o !== 1'h1);
				wr(8'h10, lw);
				wr(8'h14, rw);
			end
			chk("frame", {lw[15:0], rw[15:0]}, frame);
		end
		rdr(8'h18);
		chk("status running", 32'h1, rd & 32'h5);
		hlen(1'b0);
		chk("bit clock high", bit_clks(1) / 2, n);
		hlen(1'b1);
		chk("sync high", 16 * bit_clks(1), n);
		conclude();
	end
endmodule
